// ===== hw/pdp_defs.svh
// Timing constants and reset values for the parallel download port.
// Included by pdp_out_port and pdp_top; it holds definitions only.
// What this block does
// - Two 8-bit parallel ports: output port drives strobe/data, input port mirrors.
// - Sender pulses strobe to mark the byte on the data lines as valid.
// - Receiver drives acknowledge after taking the byte; sender takes it as confirmation.
// - Receiver asserts busy while unable to accept; sender withholds strobes meanwhile.
// - Input port ignores the paper-empty and error inputs entirely.
// - Download mode is picked at start-up; then files arrive over the input port.
// - Non-load data passes straight through to the output port.
// - Load while port occupied reports serial selection and downloads over serial channel.
`ifndef PDP_DEFS_SVH
`define PDP_DEFS_SVH

`define PDP_CLK_MHZ 40
`define PDP_SETUP_NS 500
`define PDP_STROBE_NS 1000
`define PDP_HOLD_NS 500
`define PDP_ACK_NS 2000
`define PDP_NS_TO_CYC(ns) (((ns) * `PDP_CLK_MHZ + 999) / 1000)
`define PDP_SETUP_CYC `PDP_NS_TO_CYC(`PDP_SETUP_NS)
`define PDP_STROBE_CYC `PDP_NS_TO_CYC(`PDP_STROBE_NS)
`define PDP_HOLD_CYC `PDP_NS_TO_CYC(`PDP_HOLD_NS)
`define PDP_ACK_CYC `PDP_NS_TO_CYC(`PDP_ACK_NS)
`define PDP_STRAP_WAIT 2'h3
`define PDP_BYTE_RST 8'h00

`endif

// ===== hw/pdp_fwd_if.sv
// Carrier between the receive logic and the output-port sender.
// Both ends sit on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface pdp_fwd_if;
  logic [7:0] byte_data;
  logic valid;
  logic idle;
  logic ack_n_s;
  logic busy_s;
  modport top (output byte_data, output valid, output ack_n_s, output busy_s, input idle);
  modport sender (input byte_data, input valid, input ack_n_s, input busy_s, output idle);
endinterface
`default_nettype wire

// ===== hw/pdp_out_port.sv
// Output-port sender: drives one byte at a time to the printer side.
// Assumes acknowledge and busy arrive already synchronised.
`timescale 1ns/1ps
`default_nettype none
`include "pdp_defs.svh"
module pdp_out_port
  import pdp_pkg::*;
(
  input wire logic clk_i, // System clock
  input wire logic rst_i, // Async reset, high
  pdp_fwd_if.sender fwd, // Byte hand-off
  output logic strobe_n_o, // Output strobe, low active
  output logic [7:0] data_o // Output data
);
  localparam logic [7:0] SETUP_CYC = 8'(`PDP_SETUP_CYC);
  localparam logic [7:0] STROBE_CYC = 8'(`PDP_STROBE_CYC);
  localparam logic [7:0] HOLD_CYC = 8'(`PDP_HOLD_CYC);

  pdp_tx_type state_r;
  logic [7:0] cnt_r;
  logic ack_d_r;
  logic acked_r;

  always_ff @(posedge clk_i or posedge rst_i)
    if (rst_i)
      ack_d_r <= 1'b1;
    else
      ack_d_r <= fwd.ack_n_s;

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state_r <= TX_IDLE;
      cnt_r <= 8'h00;
      acked_r <= 1'b0;
      strobe_n_o <= 1'b1;
      data_o <= `PDP_BYTE_RST;
    end
    else
    begin
      unique case (state_r)
        TX_IDLE:
          if (fwd.valid)
          begin
            data_o <= fwd.byte_data;
            cnt_r <= SETUP_CYC;
            state_r <= TX_SETUP;
          end
        TX_SETUP:
          // No strobe while the printer reports busy
          if (cnt_r > 8'h01)
            cnt_r <= cnt_r - 8'h01;
          else if (!fwd.busy_s)
          begin
            strobe_n_o <= 1'b0;
            cnt_r <= STROBE_CYC;
            acked_r <= 1'b0;
            state_r <= TX_STROBE;
          end
        TX_STROBE:
          if (cnt_r > 8'h01)
            cnt_r <= cnt_r - 8'h01;
          else
          begin
            strobe_n_o <= 1'b1;
            cnt_r <= HOLD_CYC;
            state_r <= TX_HOLD;
          end
        TX_HOLD:
          if (cnt_r > 8'h01)
            cnt_r <= cnt_r - 8'h01;
          else
            state_r <= TX_WAIT;
        TX_WAIT:
          // Byte done once acknowledged and busy dropped
          if ((acked_r || (ack_d_r && !fwd.ack_n_s)) && !fwd.busy_s)
            state_r <= TX_IDLE;
        default:
          state_r <= TX_IDLE;
      endcase
      if (state_r != TX_IDLE && state_r != TX_SETUP && ack_d_r && !fwd.ack_n_s)
        acked_r <= 1'b1;
    end
  end

  assign fwd.idle = (state_r == TX_IDLE);
endmodule
`default_nettype wire

// ===== hw/pdp_pkg.sv
// Types shared by the parallel download port modules.
// Assumes nothing beyond a SystemVerilog compiler.
package pdp_pkg;
  typedef enum logic [1:0] {RX_IDLE, RX_FWD, RX_ACK, RX_REL} pdp_rx_type;
  typedef enum logic [2:0] {TX_IDLE, TX_SETUP, TX_STROBE, TX_HOLD, TX_WAIT} pdp_tx_type;
endpackage

// ===== hw/pdp_top.sv
// Parallel download port: input port receiver, load capture and pass-through.
// Assumes pins come from outside the clock domain; load requests do not.
`timescale 1ns/1ps
`default_nettype none
`include "pdp_defs.svh"
module pdp_top
  import pdp_pkg::*;
(
  input wire logic CLOCK_I, // 40 MHz clock
  input wire logic RST_I, // Async reset, high
  input wire logic IN_DATA_STROBE_N_I, // Input port strobe, low
  input wire logic [7:0] IN_DATA_I, // Input port data
  output logic IN_ACK_N_O, // Input port acknowledge, low
  output logic IN_BUSY_O, // Input port busy, high
  input wire logic IN_PAPER_EMPTY_I, // Unused, pulled high
  input wire logic IN_ERROR_N_I, // Unused, pulled high
  output logic OUT_DATA_STROBE_N_O, // Output port strobe, low
  output logic [7:0] OUT_DATA_O, // Output port data
  input wire logic OUT_ACK_N_I, // Output port acknowledge, low
  input wire logic OUT_BUSY_I, // Output port busy, high
  input wire logic DOWNLOAD_MODE_I, // Start-up strap, high selects download
  input wire logic LOAD_REQ_I, // Load command issued, pulse
  input wire logic LOAD_DONE_I, // Load command finished, pulse
  output logic LOAD_ACTIVE_O, // Parallel load in progress
  output logic [7:0] DL_DATA_O, // Captured download byte
  output logic DL_VALID_O, // Download byte valid, pulse
  output logic SERIAL_SEL_O // Load falls back to serial, pulse
);
  localparam logic [7:0] ACK_CYC = 8'(`PDP_ACK_CYC);

  pdp_fwd_if fwd ();

  pdp_rx_type rx_state_r;
  logic strobe_s1_r, strobe_s2_r, strobe_s3_r;
  logic [7:0] dat_s1_r, dat_s2_r;
  logic ack_s1_r, ack_s2_r;
  logic bsy_s1_r, bsy_s2_r;
  logic mode_s1_r, mode_s2_r;
  logic [1:0] strap_cnt_r;
  logic mode_r;
  logic [7:0] byte_r;
  logic [7:0] cnt_r;
  logic fwd_valid_r;
  logic strobe_fall;
  logic occupied;

  // Paper-empty and error carry no meaning here
  logic unused_ok;
  assign unused_ok = IN_PAPER_EMPTY_I & IN_ERROR_N_I;

  // Third stage only finds the falling edge; reset high so no false edge
  always_ff @(posedge CLOCK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      strobe_s1_r <= 1'b1;
      strobe_s2_r <= 1'b1;
      strobe_s3_r <= 1'b1;
    end
    else
    begin
      strobe_s1_r <= IN_DATA_STROBE_N_I;
      strobe_s2_r <= strobe_s1_r;
      strobe_s3_r <= strobe_s2_r;
    end
  end

  // Data settles before the strobe, so bitwise sync is safe
  always_ff @(posedge CLOCK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      dat_s1_r <= `PDP_BYTE_RST;
      dat_s2_r <= `PDP_BYTE_RST;
    end
    else
    begin
      dat_s1_r <= IN_DATA_I;
      dat_s2_r <= dat_s1_r;
    end
  end

  always_ff @(posedge CLOCK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      ack_s1_r <= 1'b1;
      ack_s2_r <= 1'b1;
      bsy_s1_r <= 1'b0;
      bsy_s2_r <= 1'b0;
    end
    else
    begin
      ack_s1_r <= OUT_ACK_N_I;
      ack_s2_r <= ack_s1_r;
      bsy_s1_r <= OUT_BUSY_I;
      bsy_s2_r <= bsy_s1_r;
    end
  end

  always_ff @(posedge CLOCK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      mode_s1_r <= 1'b0;
      mode_s2_r <= 1'b0;
    end
    else
    begin
      mode_s1_r <= DOWNLOAD_MODE_I;
      mode_s2_r <= mode_s1_r;
    end
  end

  assign strobe_fall = strobe_s3_r && !strobe_s2_r;

  // Strap caught once, after the synchroniser has filled
  always_ff @(posedge CLOCK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      strap_cnt_r <= 2'h0;
      mode_r <= 1'b0;
    end
    else if (strap_cnt_r != `PDP_STRAP_WAIT)
    begin
      strap_cnt_r <= strap_cnt_r + 2'h1;
      if (strap_cnt_r == `PDP_STRAP_WAIT - 2'h1)
        mode_r <= mode_s2_r;
    end
  end

  // Pass-through in flight on either side counts as occupied
  assign occupied = !fwd.idle || fwd_valid_r || (!LOAD_ACTIVE_O && rx_state_r != RX_IDLE);

  always_ff @(posedge CLOCK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      LOAD_ACTIVE_O <= 1'b0;
      SERIAL_SEL_O <= 1'b0;
    end
    else
    begin
      SERIAL_SEL_O <= 1'b0;
      if (LOAD_REQ_I && !LOAD_ACTIVE_O)
      begin
        if (mode_r && !occupied)
          LOAD_ACTIVE_O <= 1'b1;
        else
          SERIAL_SEL_O <= 1'b1;
      end
      else if (LOAD_DONE_I)
        LOAD_ACTIVE_O <= 1'b0;
    end
  end

  always_ff @(posedge CLOCK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      rx_state_r <= RX_IDLE;
      byte_r <= `PDP_BYTE_RST;
      cnt_r <= 8'h00;
      fwd_valid_r <= 1'b0;
      IN_ACK_N_O <= 1'b1;
      IN_BUSY_O <= 1'b0;
      DL_DATA_O <= `PDP_BYTE_RST;
      DL_VALID_O <= 1'b0;
    end
    else
    begin
      DL_VALID_O <= 1'b0;
      fwd_valid_r <= 1'b0;
      unique case (rx_state_r)
        RX_IDLE:
          if (strobe_fall)
          begin
            IN_BUSY_O <= 1'b1;
            byte_r <= dat_s2_r;
            rx_state_r <= RX_FWD;
          end
        RX_FWD:
          if (LOAD_ACTIVE_O)
          begin
            DL_DATA_O <= byte_r;
            DL_VALID_O <= 1'b1;
            IN_ACK_N_O <= 1'b0;
            cnt_r <= ACK_CYC;
            rx_state_r <= RX_ACK;
          end
          else if (fwd.idle)
          begin
            // No buffer: busy holds the host until the printer side frees
            fwd_valid_r <= 1'b1;
            IN_ACK_N_O <= 1'b0;
            cnt_r <= ACK_CYC;
            rx_state_r <= RX_ACK;
          end
        RX_ACK:
          if (cnt_r > 8'h01)
            cnt_r <= cnt_r - 8'h01;
          else
          begin
            IN_ACK_N_O <= 1'b1;
            rx_state_r <= RX_REL;
          end
        RX_REL:
          if (strobe_s2_r)
          begin
            IN_BUSY_O <= 1'b0;
            rx_state_r <= RX_IDLE;
          end
      endcase
    end
  end

  assign fwd.byte_data = byte_r;
  assign fwd.valid = fwd_valid_r;
  assign fwd.ack_n_s = ack_s2_r;
  assign fwd.busy_s = bsy_s2_r;

  pdp_out_port u_out (
    .clk_i(CLOCK_I),
    .rst_i(RST_I),
    .fwd(fwd),
    .strobe_n_o(OUT_DATA_STROBE_N_O),
    .data_o(OUT_DATA_O)
  );
endmodule
`default_nettype wire

// ===== test/parallel_download_port_tb_top.sv
// Bench for pdp_top: host on the input port, printer model on the output.
// Assumes the printer model and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module parallel_download_port_tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic strobe_n = 1'b1;
  logic [7:0] din = 8'h00;
  logic paper_empty = 1'b1;
  logic err_n = 1'b1;
  logic req = 1'b0;
  logic done = 1'b0;
  logic stall = 1'b0;
  logic dl_mode = 1'b1;
  logic ack_n, busy, o_strobe_n, o_ack, o_busy, load_act, dl_valid, ser;
  logic [7:0] o_data, dl_data, p_last, p_cnt;
  logic [7:0] dl_last = 8'h00;
  logic [7:0] dl_cnt = 8'h00;
  int bad_count = 0;
  int total_checks = 0;
  pdp_top u_dut (.CLOCK_I(clk), .RST_I(rst), .IN_DATA_STROBE_N_I(strobe_n), .IN_DATA_I(din), .IN_ACK_N_O(ack_n),
    .IN_BUSY_O(busy), .IN_PAPER_EMPTY_I(paper_empty), .IN_ERROR_N_I(err_n), .OUT_DATA_STROBE_N_O(o_strobe_n),
    .OUT_DATA_O(o_data), .OUT_ACK_N_I(o_ack), .OUT_BUSY_I(o_busy), .DOWNLOAD_MODE_I(dl_mode),
    .LOAD_REQ_I(req), .LOAD_DONE_I(done), .LOAD_ACTIVE_O(load_act), .DL_DATA_O(dl_data),
    .DL_VALID_O(dl_valid), .SERIAL_SEL_O(ser));
  pdp_printer_model u_prn (.clk_i(clk), .rst_i(rst), .strobe_n_i(o_strobe_n), .data_i(o_data), .stall_i(stall),
    .ack_n_o(o_ack), .busy_o(o_busy), .last_o(p_last), .count_o(p_cnt));
  initial
  begin
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk)
    if (dl_valid === 1'b1)
    begin
      dl_last <= dl_data;
      dl_cnt <= dl_cnt + 8'h01;
    end
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic host_send(input logic [7:0] b);
    for (int n = 0; n < 4000 && busy !== 1'b0; n++) @(negedge clk);
    chk("busy before strobe", {7'h00, busy}, 8'h00);
    @(posedge clk);
    din <= b;
    repeat (3) @(posedge clk);
    strobe_n <= 1'b0;
    repeat (4) @(posedge clk);
    strobe_n <= 1'b1;
    for (int n = 0; n < 4000 && ack_n !== 1'b0; n++) @(negedge clk);
    chk("ack low", {7'h00, ack_n}, 8'h00);
    chk("busy in ack", {7'h00, busy}, 8'h01);
    for (int n = 0; n < 200 && ack_n !== 1'b1; n++) @(negedge clk);
    chk("ack released", {7'h00, ack_n}, 8'h01);
    @(posedge clk);
    din <= ~b; // Old byte no longer valid
  endtask
  task automatic wait_prn(input logic [7:0] n_exp);
    for (int n = 0; n < 4000 && p_cnt !== n_exp; n++) @(negedge clk);
    chk("printer count", p_cnt, n_exp);
  endtask
  task automatic t_pass;
    stall <= 1'b1;
    fork
      begin
        repeat (300) @(posedge clk);
        stall <= 1'b0;
      end
      host_send(8'ha5);
    join
    wait_prn(8'h01);
    chk("printer byte", p_last, 8'ha5);
    host_send(8'h3c);
    wait_prn(8'h02);
    chk("printer byte", p_last, 8'h3c);
    chk("download count", dl_cnt, 8'h00);
  endtask
  task automatic t_load;
    // Last pass-through byte must clear both ports, else the load is refused
    repeat (150) @(posedge clk);
    req <= 1'b1;
    @(posedge clk);
    req <= 1'b0;
    paper_empty <= 1'b0;
    err_n <= 1'b0;
    @(negedge clk);
    chk("load active", {7'h00, load_act}, 8'h01);
    host_send(8'h5a);
    chk("download byte", dl_last, 8'h5a);
    chk("printer count", p_cnt, 8'h02);
    @(posedge clk);
    done <= 1'b1;
    paper_empty <= 1'b1;
    err_n <= 1'b1;
    @(posedge clk);
    done <= 1'b0;
    @(negedge clk);
    chk("load ended", {7'h00, load_act}, 8'h00);
  endtask
  task automatic t_refuse;
    stall <= 1'b1;
    fork
      begin
        repeat (200) @(posedge clk);
        req <= 1'b1;
        @(posedge clk);
        req <= 1'b0;
        @(negedge clk);
        chk("serial select", {6'h00, ser, load_act}, 8'h02);
        repeat (100) @(posedge clk);
        stall <= 1'b0;
      end
      host_send(8'h77);
    join
    wait_prn(8'h03);
    chk("printer byte", p_last, 8'h77);
  endtask
  task automatic t_no_mode;
    repeat (150) @(posedge clk);
    // Second reset with the strap low: every load goes serial
    dl_mode <= 1'b0;
    rst <= 1'b1;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    repeat (6) @(posedge clk);
    @(negedge clk);
    chk("idle pins", {4'h0, ack_n, busy, o_strobe_n, load_act}, 8'h0a);
    @(posedge clk);
    req <= 1'b1;
    @(posedge clk);
    req <= 1'b0;
    @(negedge clk);
    chk("serial select", {6'h00, ser, load_act}, 8'h02);
  endtask
  initial
  begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    repeat (6) @(posedge clk);
    @(negedge clk);
    chk("idle pins", {4'h0, ack_n, busy, o_strobe_n, load_act}, 8'h0a);
    t_pass;
    t_load;
    t_refuse;
    t_no_mode;
    complete_run;
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    bad_count++;
    complete_run;
  end
endmodule
`default_nettype wire

// ===== test/pdp_printer_model.sv
// Printer on the output port: busy on strobe, then an ack pulse.
// Assumes the bench clock; stall_i holds busy to refuse strobes.
`timescale 1ns/1ps
`default_nettype none
module pdp_printer_model (
  input wire logic clk_i, // Clock
  input wire logic rst_i, // Reset, high
  input wire logic strobe_n_i, // Strobe, low
  input wire logic [7:0] data_i, // Data
  input wire logic stall_i, // Hold busy
  output logic ack_n_o, // Ack, low
  output logic busy_o, // Busy, high
  output logic [7:0] last_o, // Last byte
  output logic [7:0] count_o // Byte count
);
  logic [3:0] cnt_r;
  logic took_r;
  always_ff @(posedge clk_i or posedge rst_i)
    if (rst_i)
    begin
      cnt_r <= 4'h0;
      took_r <= 1'b0;
      ack_n_o <= 1'b1;
      last_o <= 8'h00;
      count_o <= 8'h00;
    end
    else if (!strobe_n_i && !took_r)
    begin
      took_r <= 1'b1;
      last_o <= data_i;
      count_o <= count_o + 8'h01;
    end
    else if (took_r && strobe_n_i)
    begin
      cnt_r <= cnt_r + 4'h1;
      ack_n_o <= !(cnt_r inside {[4'h4:4'hb]});
      if (cnt_r == 4'hf) took_r <= 1'b0;
    end
  assign busy_o = took_r || stall_i;
endmodule
`default_nettype wire

// ===== test/pdp_props.sv
// Pin-level checker for pdp_top, bound to every instance.
// Assumes one clock domain and the 80/40 cycle pulse widths.
`timescale 1ns/1ps
`default_nettype none
module pdp_props (
  input wire logic CLOCK_I, // Clock
  input wire logic RST_I, // Reset
  input wire logic IN_DATA_STROBE_N_I, // In strobe
  input wire logic IN_ACK_N_O, // In ack
  input wire logic IN_BUSY_O, // In busy
  input wire logic OUT_DATA_STROBE_N_O, // Out strobe
  input wire logic [7:0] OUT_DATA_O, // Out data
  input wire logic OUT_BUSY_I, // Out busy
  input wire logic LOAD_REQ_I, // Load request
  input wire logic LOAD_ACTIVE_O, // Load active
  input wire logic SERIAL_SEL_O // Serial fallback
);
  logic [7:0] ack_cnt_r;
  logic [7:0] strobe_cnt_r;
  // Counters of low cycles, far cheaper than long repetitions
  always_ff @(posedge CLOCK_I or posedge RST_I)
    if (RST_I) ack_cnt_r <= 8'h00;
    else ack_cnt_r <= IN_ACK_N_O ? 8'h00 : ack_cnt_r + 8'h01;
  always_ff @(posedge CLOCK_I or posedge RST_I)
    if (RST_I) strobe_cnt_r <= 8'h00;
    else strobe_cnt_r <= OUT_DATA_STROBE_N_O ? 8'h00 : strobe_cnt_r + 8'h01;
  default clocking @(posedge CLOCK_I); endclocking
  default disable iff (RST_I);
  a_busy_on_strobe: assert property ($fell(IN_DATA_STROBE_N_I) && !IN_BUSY_O |-> ##[1:5] IN_BUSY_O)
    else $error("busy late");
  a_ack_width: assert property ($rose(IN_ACK_N_O) |-> ack_cnt_r == 8'h50)
    else $error("ack width");
  a_ack_in_busy: assert property (!IN_ACK_N_O |-> IN_BUSY_O)
    else $error("ack outside busy");
  a_busy_release: assert property ($fell(IN_BUSY_O) |-> $past(IN_ACK_N_O) && $past(IN_DATA_STROBE_N_I, 2))
    else $error("busy fell early");
  a_out_wait_busy: assert property ($fell(OUT_DATA_STROBE_N_O) |-> !$past(OUT_BUSY_I, 3))
    else $error("strobe while busy");
  a_out_strobe_width: assert property ($rose(OUT_DATA_STROBE_N_O) |-> strobe_cnt_r == 8'h28)
    else $error("strobe width");
  a_out_data_hold: assert property (!OUT_DATA_STROBE_N_O || $rose(OUT_DATA_STROBE_N_O) |-> $stable(OUT_DATA_O))
    else $error("data moved");
  a_serial_cause: assert property (SERIAL_SEL_O |-> $past(LOAD_REQ_I) && !LOAD_ACTIVE_O ##1 !SERIAL_SEL_O)
    else $error("serial pulse");
  c_serial: cover property (SERIAL_SEL_O);
  c_load: cover property ($rose(LOAD_ACTIVE_O));
  c_out: cover property ($fell(OUT_DATA_STROBE_N_O));
endmodule
bind pdp_top pdp_props u_props (
  .CLOCK_I(CLOCK_I),
  .RST_I(RST_I),
  .IN_DATA_STROBE_N_I(IN_DATA_STROBE_N_I),
  .IN_ACK_N_O(IN_ACK_N_O),
  .IN_BUSY_O(IN_BUSY_O),
  .OUT_DATA_STROBE_N_O(OUT_DATA_STROBE_N_O),
  .OUT_DATA_O(OUT_DATA_O),
  .OUT_BUSY_I(OUT_BUSY_I),
  .LOAD_REQ_I(LOAD_REQ_I),
  .LOAD_ACTIVE_O(LOAD_ACTIVE_O),
  .SERIAL_SEL_O(SERIAL_SEL_O)
);
`default_nettype wire
